/* hdl/uiel_line_status.sv */
// uart interrupt enable, interrupt status, line status and fifo modes,
// with the receive and transmit fifos and the plain configuration registers.
// assumes one clock; the register port, receiver and transmitter are all
// synchronous to i_clk.
`timescale 1ns/1ps

module uiel_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = uiel_pkg::FIFO_DEPTH,
  localparam int AW   = (DEPTH > 1) ? $clog2(DEPTH) : 1,
  localparam int CW   = $clog2(DEPTH + 1)
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_clear,
  // filling side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // draining side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data,
  output logic [CW-1:0]         o_level
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [CW-1:0]    count_ff;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign o_in_ready  = (count_ff != CW'(DEPTH));
  assign o_out_valid = (count_ff != '0);
  assign o_out_data  = mem[rd_ptr_ff];
  assign o_level     = count_ff;
  assign push        = i_in_valid & o_in_ready;
  assign pop         = i_out_ready & o_out_valid;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else if (i_clear) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= bump(wr_ptr_ff);
      end
      if (pop) begin
        rd_ptr_ff <= bump(rd_ptr_ff);
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule // uiel_fifo

module uiel_line_status #(
  parameter int DEPTH = uiel_pkg::FIFO_DEPTH,
  localparam int CW   = $clog2(DEPTH + 1)
) (
  // clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  // register port
  input  wire uiel_pkg::uiel_reg_req_t  i_reg_req,
  output logic [7:0]                    o_reg_rdata,
  output logic                          o_reg_rvalid,
  // receiver side
  input  wire logic                     i_rx_valid,
  input  wire uiel_pkg::uiel_rx_word_t  i_rx_word,
  output logic                          o_rx_ready,
  // transmitter side
  output logic                          o_tx_valid,
  output logic [7:0]                    o_tx_data,
  input  wire logic                     i_tx_ready,
  input  wire logic                     i_tsr_empty,
  // modem lines
  input  wire logic [3:0]               i_modem_in,
  input  wire logic [3:0]               i_modem_delta,
  // interrupt
  output logic                          o_irq
);
  import uiel_pkg::*;

  logic [7:0]    ier_ff;
  logic [7:0]    lcr_ff;
  logic [7:0]    fcr_ff;
  logic [7:0]    cfg_ff [SLOT_CNT];
  logic          ovr_ff;
  logic          tx_irq_ff;
  logic          tx_cond_q_ff;
  logic [3:0]    msr_delta_ff;
  logic [CW-1:0] err_cnt_ff;
  logic [7:0]    rdata_ff;
  logic          rvalid_ff;
  logic          irq_ff;

  logic          wr;
  logic          rd;
  logic [3:0]    addr;
  logic [3:0]    slot;
  logic          plain;
  logic          fifo_en;
  logic          thr_wr;
  logic          rhr_rd;
  logic          isr_rd;
  logic          lsr_rd;
  logic          msr_rd;
  logic          ier_wr;
  logic          fcr_wr;
  logic          sw_rst;
  logic          rx_clear;
  logic          tx_clear;
  logic          rx_room;
  logic          rx_push;
  logic          rx_pop;
  logic          rx_overrun;
  logic          rx_in_ready;
  logic          rx_out_valid;
  uiel_rx_word_t rx_head;
  logic [CW-1:0] rx_level;
  logic          tx_room;
  logic          tx_in_ready;
  logic [CW-1:0] tx_level;
  logic [CW-1:0] tx_space;
  logic          thr_empty;
  logic          tx_cond;
  logic          tx_set;
  logic          ls_pend;
  logic          rx_pend;
  logic          tx_pend;
  logic          ms_pend;
  logic [7:0]    line_status;
  logic [7:0]    irq_status_reg;
  logic [7:0]    nxt_rdata;
  logic [7:0]    nxt_ier;

  // which plain register, if any, an offset reaches under the current
  // line control value; the enhanced key hides several normal registers
  function automatic logic [3:0] slot_of(input logic [3:0] a,
                                         input logic [7:0] line_ctrl_reg,
                                         input logic       enh);
    if (a == ADDR_HOLD && line_ctrl_reg[LCR_DIV_BIT]) begin
      slot_of = SLOT_DLL;
    end else if (a == ADDR_IER && line_ctrl_reg[LCR_DIV_BIT]) begin
      slot_of = SLOT_DLM;
    end else if (a == ADDR_ISR && line_ctrl_reg == LCR_ENH_KEY) begin
      slot_of = SLOT_EFR;
    end else if (a == ADDR_ISR && line_ctrl_reg[LCR_DIV_BIT] && enh) begin
      slot_of = SLOT_DLD;
    end else if (a >= ADDR_RESUME_CHAR_ONE && a <= ADDR_PAUSE_CHAR_TWO && line_ctrl_reg == LCR_ENH_KEY) begin
      slot_of = a;
    end else if (a == ADDR_MCR) begin
      slot_of = SLOT_MCR;
    end else if (a == ADDR_SPR) begin
      slot_of = SLOT_SPR;
    end else if (a == ADDR_RSVD) begin
      slot_of = SLOT_NONE;
    end else if (a >= ADDR_GDIR) begin
      // the reserved offset has no slot, so offsets above it shift down one
      slot_of = (a > ADDR_RSVD) ? a - 4'h1 : a;
    end else begin
      slot_of = SLOT_NONE;
    end
  endfunction

  function automatic logic [7:0] cfg_mask(input logic [3:0] s);
    if (s == SLOT_GCTL) begin
      cfg_mask = GCTL_MSK;
    end else if (s == SLOT_EXTRA_FEATURE_CTRL) begin
      cfg_mask = EXTRA_FEATURE_CTRL_MSK;
    end else if (s >= SLOT_GDIR) begin
      cfg_mask = GPIO_MSK;
    end else begin
      cfg_mask = 8'hFF;
    end
  endfunction

  function automatic logic [7:0] trig(input logic [1:0] sel,
                                      input logic       is_rx);
    case (sel)
      2'h0:    trig = is_rx ? RX_TRIG0 : TX_TRIG0;
      2'h1:    trig = is_rx ? RX_TRIG1 : TX_TRIG1;
      2'h2:    trig = is_rx ? RX_TRIG2 : TX_TRIG2;
      default: trig = is_rx ? RX_TRIG3 : TX_TRIG3;
    endcase
  endfunction

  // register port decode
  assign wr      = i_reg_req.wr;
  assign rd      = i_reg_req.rd;
  assign addr    = i_reg_req.addr;
  assign slot    = slot_of(addr, lcr_ff, cfg_ff[SLOT_EFR][EFR_ENH_BIT]);
  assign plain   = (slot == SLOT_NONE);
  assign fifo_en = fcr_ff[FCR_EN_BIT];
  assign thr_wr  = wr & plain & (addr == ADDR_HOLD);
  assign rhr_rd  = rd & plain & (addr == ADDR_HOLD);
  assign isr_rd  = rd & plain & (addr == ADDR_ISR);
  assign lsr_rd  = rd & plain & (addr == ADDR_LSR);
  assign msr_rd  = rd & plain & (addr == ADDR_MSR);
  assign ier_wr  = wr & plain & (addr == ADDR_IER);
  assign fcr_wr  = wr & plain & (addr == ADDR_ISR);
  assign sw_rst  = wr & (slot == SLOT_GCTL) & i_reg_req.wdata[GCTL_SWRST];

  // fifo resets only act with the enable bit set; toggling the enable
  // also flushes, so stale data never crosses a mode change
  assign rx_clear = sw_rst | (fcr_wr & (i_reg_req.wdata[FCR_EN_BIT] != fifo_en))
                  | (fcr_wr & i_reg_req.wdata[FCR_EN_BIT]
                     & i_reg_req.wdata[FCR_RXCLR_BIT]);
  assign tx_clear = sw_rst | (fcr_wr & (i_reg_req.wdata[FCR_EN_BIT] != fifo_en))
                  | (fcr_wr & i_reg_req.wdata[FCR_EN_BIT]
                     & i_reg_req.wdata[FCR_TXCLR_BIT]);

  // receive path: without fifos only one character is held
  assign rx_room    = ~cfg_ff[SLOT_EXTRA_FEATURE_CTRL][EXTRA_FEATURE_CTRL_RXDIS]
                    & (fifo_en ? rx_in_ready : (rx_level == '0));
  assign rx_push    = i_rx_valid & rx_room & ~rx_clear;
  assign rx_overrun = i_rx_valid & ~rx_room & ~cfg_ff[SLOT_EXTRA_FEATURE_CTRL][EXTRA_FEATURE_CTRL_RXDIS];
  assign rx_pop     = rhr_rd & rx_out_valid;
  assign o_rx_ready = rx_room;

  uiel_fifo #(
    .WIDTH (9 + 2),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_clear     (rx_clear),
    .i_in_valid  (rx_push),
    .o_in_ready  (rx_in_ready),
    .i_in_data   (i_rx_word),
    .o_out_valid (rx_out_valid),
    .i_out_ready (rx_pop),
    .o_out_data  (rx_head),
    .o_level     (rx_level)
  );

  // transmit path: a holding write while full is dropped
  assign tx_room = fifo_en ? tx_in_ready : (tx_level == '0);

  uiel_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) u_tx_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_clear     (tx_clear),
    .i_in_valid  (thr_wr & tx_room),
    .o_in_ready  (tx_in_ready),
    .i_in_data   (i_reg_req.wdata),
    .o_out_valid (o_tx_valid),
    .i_out_ready (i_tx_ready),
    .o_out_data  (o_tx_data),
    .o_level     (tx_level)
  );

  assign tx_space  = CW'(DEPTH) - tx_level;
  assign thr_empty = (tx_level == '0);

  // line status
  assign line_status[0]   = rx_out_valid;
  assign line_status[1]   = ovr_ff;
  assign line_status[2]   = rx_out_valid & rx_head.parity_err;
  assign line_status[3]   = rx_out_valid & rx_head.frame_err;
  assign line_status[4]   = rx_out_valid & rx_head.brk;
  assign line_status[5]   = thr_empty;
  assign line_status[6]   = thr_empty & i_tsr_empty;
  assign line_status[7]   = (err_cnt_ff != '0);

  // pending sources, each gated by its enable; all clear gives polled mode
  assign ls_pend = ier_ff[IER_LS_BIT] & (|line_status[4:1] | line_status[7]);
  assign rx_pend = ier_ff[IER_RX_BIT]
                 & (fifo_en ? (8'(rx_level) >= trig(fcr_ff[7:6], 1'b1))
                            : rx_out_valid);
  assign tx_pend = ier_ff[IER_TX_BIT] & tx_irq_ff;
  assign ms_pend = ier_ff[IER_MS_BIT] & (|msr_delta_ff);

  assign tx_cond = fifo_en ? (8'(tx_space) > trig(fcr_ff[5:4], 1'b0))
                           : thr_empty;
  assign nxt_ier = {cfg_ff[SLOT_EFR][EFR_ENH_BIT] ? i_reg_req.wdata[7:4]
                                                  : ier_ff[7:4],
                    i_reg_req.wdata[3:0] & IER_STD_MSK[3:0]};
  assign tx_set  = tx_cond & ((~tx_cond_q_ff)
                 | (ier_wr & nxt_ier[IER_TX_BIT] & ~ier_ff[IER_TX_BIT]));

  always_comb begin
    irq_status_reg = {fifo_en, fifo_en, ISR_NONE};
    if (ls_pend) begin
      irq_status_reg[5:0] = ISR_LS;
    end else if (rx_pend) begin
      irq_status_reg[5:0] = ISR_RX;
    end else if (tx_pend) begin
      irq_status_reg[5:0] = ISR_TX;
    end else if (ms_pend) begin
      irq_status_reg[5:0] = ISR_MS;
    end
  end

  always_comb begin
    nxt_rdata = 8'h00;
    if (!plain) begin
      nxt_rdata = cfg_ff[slot];
      if (slot == SLOT_GDIR) begin
        nxt_rdata = cfg_ff[slot] | GDIR_FIXED;
      end else if (slot == SLOT_GCTL) begin
        nxt_rdata = cfg_ff[slot] | GCTL_FIXED;
      end
    end else if (addr == ADDR_HOLD) begin
      nxt_rdata = rx_out_valid ? rx_head.data : 8'h00;
    end else if (addr == ADDR_IER) begin
      nxt_rdata = ier_ff;
    end else if (addr == ADDR_ISR) begin
      nxt_rdata = irq_status_reg;
    end else if (addr == ADDR_LCR) begin
      nxt_rdata = lcr_ff;
    end else if (addr == ADDR_LSR) begin
      nxt_rdata = line_status;
    end else if (addr == ADDR_MSR) begin
      nxt_rdata = {i_modem_in, msr_delta_ff};
    end else if (addr == ADDR_TXLVL) begin
      nxt_rdata = 8'(tx_space);
    end else if (addr == ADDR_RXLVL) begin
      nxt_rdata = 8'(rx_level);
    end
  end

  // control registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ier_ff <= IER_RST;
      lcr_ff <= LCR_RST;
      fcr_ff <= FCR_RST;
    end else begin
      if (ier_wr) begin
        ier_ff <= nxt_ier;
      end
      if (wr && addr == ADDR_LCR) begin
        lcr_ff <= i_reg_req.wdata;
      end
      if (sw_rst) begin
        fcr_ff <= FCR_RST;
      end else if (fcr_wr) begin
        // other fields only program together with the enable bit
        fcr_ff <= i_reg_req.wdata[FCR_EN_BIT]
                ? {i_reg_req.wdata[7:6],
                   cfg_ff[SLOT_EFR][EFR_ENH_BIT] ? i_reg_req.wdata[5:4]
                                                 : fcr_ff[5:4],
                   i_reg_req.wdata[3], 3'b001}
                : FCR_RST;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < SLOT_CNT; i++) begin
        cfg_ff[i] <= CFG_RST;
      end
    end else if (wr && !plain) begin
      cfg_ff[slot] <= i_reg_req.wdata & cfg_mask(slot);
    end
  end

  // error bookkeeping; a new event beats a clearing read
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ovr_ff     <= 1'b0;
      err_cnt_ff <= '0;
    end else begin
      if (rx_overrun) begin
        ovr_ff <= 1'b1;
      end else if (lsr_rd) begin
        ovr_ff <= 1'b0;
      end
      if (rx_clear) begin
        err_cnt_ff <= '0;
      end else if (rx_push && |i_rx_word[10:8]
                   && !(rx_pop && |rx_head[10:8])) begin
        err_cnt_ff <= err_cnt_ff + 1'b1;
      end else if (rx_pop && |rx_head[10:8]
                   && !(rx_push && |i_rx_word[10:8])) begin
        err_cnt_ff <= err_cnt_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_irq_ff    <= 1'b0;
      tx_cond_q_ff <= 1'b1;
      msr_delta_ff <= 4'h0;
    end else begin
      tx_cond_q_ff <= tx_cond;
      if (tx_set) begin
        tx_irq_ff <= 1'b1;
      end else if (isr_rd || thr_wr) begin
        tx_irq_ff <= 1'b0;
      end
      msr_delta_ff <= i_modem_delta | (msr_rd ? 4'h0 : msr_delta_ff);
    end
  end

  // outputs
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
      irq_ff    <= 1'b0;
    end else begin
      rvalid_ff <= rd;
      if (rd) begin
        rdata_ff <= nxt_rdata;
      end
      irq_ff <= ls_pend | rx_pend | tx_pend | ms_pend;
    end
  end

  assign o_reg_rdata  = rdata_ff;
  assign o_reg_rvalid = rvalid_ff;
  assign o_irq        = irq_ff;
endmodule // uiel_line_status

/* hdl/uiel_pkg.sv */
// shared constants and carriers for the uart interrupt-enable / line-status
// block; assumes an 8-bit register port with 4-bit register offsets
package uiel_pkg;

  // register offsets
  localparam logic [3:0] ADDR_HOLD  = 4'h0;
  localparam logic [3:0] ADDR_IER   = 4'h1;
  localparam logic [3:0] ADDR_ISR   = 4'h2;
  localparam logic [3:0] ADDR_LCR   = 4'h3;
  localparam logic [3:0] ADDR_MCR   = 4'h4;
  localparam logic [3:0] ADDR_RESUME_CHAR_ONE  = 4'h4;
  localparam logic [3:0] ADDR_LSR   = 4'h5;
  localparam logic [3:0] ADDR_MSR   = 4'h6;
  localparam logic [3:0] ADDR_SPR   = 4'h7;
  localparam logic [3:0] ADDR_PAUSE_CHAR_TWO = 4'h7;
  localparam logic [3:0] ADDR_TXLVL = 4'h8;
  localparam logic [3:0] ADDR_RXLVL = 4'h9;
  localparam logic [3:0] ADDR_GDIR  = 4'hA;
  localparam logic [3:0] ADDR_RSVD  = 4'hD;
  localparam logic [3:0] ADDR_EXTRA_FEATURE_CTRL  = 4'hF;

  // storage slots of the plain read/write registers
  localparam logic [3:0] SLOT_DLL   = 4'h0;
  localparam logic [3:0] SLOT_DLM   = 4'h1;
  localparam logic [3:0] SLOT_DLD   = 4'h2;
  localparam logic [3:0] SLOT_EFR   = 4'h3;
  localparam logic [3:0] SLOT_RESUME_CHAR_ONE  = 4'h4;
  localparam logic [3:0] SLOT_MCR   = 4'h8;
  localparam logic [3:0] SLOT_SPR   = 4'h9;
  localparam logic [3:0] SLOT_GDIR  = 4'hA;
  localparam logic [3:0] SLOT_GCTL  = 4'hD;
  localparam logic [3:0] SLOT_EXTRA_FEATURE_CTRL  = 4'hE;
  localparam logic [3:0] SLOT_NONE  = 4'hF;
  localparam int         SLOT_CNT   = 15;

  // field positions
  localparam int LCR_DIV_BIT   = 7;
  localparam int EFR_ENH_BIT   = 4;
  localparam int IER_RX_BIT    = 0;
  localparam int IER_TX_BIT    = 1;
  localparam int IER_LS_BIT    = 2;
  localparam int IER_MS_BIT    = 3;
  localparam int FCR_EN_BIT    = 0;
  localparam int FCR_RXCLR_BIT = 1;
  localparam int FCR_TXCLR_BIT = 2;
  localparam int GCTL_SWRST    = 3;
  localparam int EXTRA_FEATURE_CTRL_RXDIS    = 1;

  // values
  localparam logic [7:0] LCR_ENH_KEY = 8'hBF;
  localparam logic [7:0] IER_RST     = 8'h00;
  localparam logic [7:0] LCR_RST     = 8'h00;
  localparam logic [7:0] FCR_RST     = 8'h00;
  localparam logic [7:0] CFG_RST     = 8'h00;
  localparam logic [7:0] IER_STD_MSK = 8'h0F;
  localparam logic [7:0] GPIO_MSK    = 8'h0F;
  localparam logic [7:0] GCTL_MSK    = 8'h01;
  localparam logic [7:0] EXTRA_FEATURE_CTRL_MSK    = 8'h06;
  localparam logic [7:0] GDIR_FIXED  = 8'h20;
  localparam logic [7:0] GCTL_FIXED  = 8'h02;

  // interrupt source codes, highest priority first
  localparam logic [5:0] ISR_LS   = 6'h06;
  localparam logic [5:0] ISR_RX   = 6'h04;
  localparam logic [5:0] ISR_TX   = 6'h02;
  localparam logic [5:0] ISR_MS   = 6'h00;
  localparam logic [5:0] ISR_NONE = 6'h01;

  // trigger levels by select code (receive fill, transmit free spaces)
  localparam logic [7:0] RX_TRIG0 = 8'h01;
  localparam logic [7:0] RX_TRIG1 = 8'h04;
  localparam logic [7:0] RX_TRIG2 = 8'h08;
  localparam logic [7:0] RX_TRIG3 = 8'h0E;
  localparam logic [7:0] TX_TRIG0 = 8'h01;
  localparam logic [7:0] TX_TRIG1 = 8'h04;
  localparam logic [7:0] TX_TRIG2 = 8'h08;
  localparam logic [7:0] TX_TRIG3 = 8'h0C;

  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic       brk;
    logic       frame_err;
    logic       parity_err;
    logic [7:0] data;
  } uiel_rx_word_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } uiel_reg_req_t;

endpackage

/* sim/uiel_line_status_chk.sv */
// port-level checker for the interrupt-enable / line-status block
// assumes the bench binds it to the top module; one clock domain
`timescale 1ns/1ps

module uiel_line_status_chk
  import uiel_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic          i_clk,
  input wire logic          i_rst_n,
  // register port
  input wire uiel_reg_req_t i_reg_req,
  input wire logic [7:0]    o_reg_rdata,
  input wire logic          o_reg_rvalid,
  // receive and transmit sides
  input wire logic          i_rx_valid,
  input wire uiel_rx_word_t i_rx_word,
  input wire logic          o_rx_ready,
  input wire logic          o_tx_valid,
  input wire logic [7:0]    o_tx_data,
  input wire logic          i_tx_ready,
  input wire logic          i_tsr_empty,
  // modem and interrupt
  input wire logic [3:0]    i_modem_delta,
  input wire logic          o_irq
);
  // shadow of line control and enables, rebuilt from host writes only
  logic [7:0] lcr_sh_ff;
  logic [3:0] ier_sh_ff;
  logic       ier_off_ff;
  logic       take_err;
  logic       lsr_rd;

  assign take_err = i_rx_valid && o_rx_ready && (|i_rx_word[10:8]);
  assign lsr_rd = i_reg_req.rd && i_reg_req.addr == ADDR_LSR
                  && lcr_sh_ff != LCR_ENH_KEY;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lcr_sh_ff  <= LCR_RST;
      ier_sh_ff  <= 4'h0;
      ier_off_ff <= 1'b1;
    end else begin
      ier_off_ff <= (ier_sh_ff == 4'h0);
      if (i_reg_req.wr && i_reg_req.addr == ADDR_LCR)
        lcr_sh_ff <= i_reg_req.wdata;
      if (i_reg_req.wr && i_reg_req.addr == ADDR_IER && !lcr_sh_ff[7])
        ier_sh_ff <= i_reg_req.wdata[3:0];
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_rst_idle: assert property ($rose(i_rst_n) |-> o_rx_ready && !o_irq && !o_tx_valid)
    else $error("outputs not idle after reset");
  a_polled_quiet: assert property (ier_sh_ff == 4'h0 && ier_off_ff |-> !o_irq)
    else $error("interrupt raised in polled mode");
  a_irq_cause: assert property ($rose(o_irq) |-> ier_sh_ff != 4'h0)
    else $error("interrupt rose with all enables clear");
  a_line_irq: assert property (take_err && ier_sh_ff[2] && !i_reg_req.wr |-> ##[1:2] o_irq)
    else $error("errored character gave no interrupt");
  a_modem_irq: assert property (ier_sh_ff[3] && (|i_modem_delta) && !i_reg_req.wr |-> ##[1:2] o_irq)
    else $error("modem change gave no interrupt");
  a_tsr_busy: assert property (lsr_rd && !i_tsr_empty |=> !o_reg_rdata[6])
    else $error("shift register busy but status shows empty");
  a_rd_answer: assert property (i_reg_req.rd |=> o_reg_rvalid ##1 !o_reg_rvalid)
    else $error("read answer missing or too long");
  a_tx_hold: assert property (o_tx_valid && !i_tx_ready && !i_reg_req.wr |=> o_tx_valid && $stable(o_tx_data))
    else $error("transmit head dropped while stalled");

  c_overrun: cover property (i_rx_valid && !o_rx_ready);
  c_line_irq: cover property (take_err ##[1:2] o_irq);
  c_tx_stall: cover property (o_tx_valid && !i_tx_ready);
endmodule // uiel_line_status_chk

/* sim/uiel_tx_model.sv */
// stand-in for the transmit shift register: takes a byte from the fifo
// and stays busy a fixed time; assumes the block's clock and reset
`timescale 1ns/1ps

module uiel_tx_model #(
  parameter int BUSY = 8
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // stall request
  input  wire logic       i_stall,
  // transmit fifo side
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready,
  output logic            o_tsr_empty,
  output logic [7:0]      o_last
);
  int busy_ff;

  // a stalled engine refuses the byte so the fifo head must wait
  assign o_tx_ready  = (busy_ff == 0) && !i_stall;
  assign o_tsr_empty = (busy_ff == 0);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_ff <= 0;
      o_last  <= 8'h00;
    end else if (i_tx_valid && o_tx_ready) begin
      busy_ff <= BUSY;
      o_last  <= i_tx_data;
    end else if (busy_ff > 0) begin
      busy_ff <= busy_ff - 1;
    end
  end
endmodule // uiel_tx_model

/* sim/uiel_line_status_tb.sv */
// self-checking bench for the line-status block: host register traffic,
// receive pushes and a transmit engine model on the far side
`timescale 1ns/1ps

module uiel_line_status_tb;
  import uiel_pkg::*;
  logic          i_clk, i_rst_n, rx_valid, stall, rvalid, rx_ready;
  logic          tx_valid, tx_ready, tsr_empty, irq;
  uiel_reg_req_t req;
  uiel_rx_word_t rx_word;
  logic [3:0]    modem_in, delta;
  logic [7:0]    rdata, tx_data, last, d;
  int            seed, err_total, check_count, cyc, n;
  logic [7:0]    q[$];

  uiel_line_status #(.DEPTH(16)) u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_req(req),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_rx_valid(rx_valid),
    .i_rx_word(rx_word), .o_rx_ready(rx_ready), .o_tx_valid(tx_valid),
    .o_tx_data(tx_data), .i_tx_ready(tx_ready), .i_tsr_empty(tsr_empty),
    .i_modem_in(modem_in), .i_modem_delta(delta), .o_irq(irq));
  uiel_tx_model u_eng (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_stall(stall),
    .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready),
    .o_tsr_empty(tsr_empty), .o_last(last));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  function automatic logic [7:0] irq_status_reg(input logic fifo, input logic [5:0] c);
    return {{2{fifo}}, c};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk) req <= '{1'b1, 1'b0, a, v};
    @(posedge i_clk) req <= '0;
  endtask

  // read with the answer awaited under a bounded count
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    int k;
    k = 0;
    @(posedge i_clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_clk) req <= '0;
    #1;
    while (rvalid !== 1'b1 && k < 3) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    check(rdata, exp);
  endtask

  task automatic push(input logic [7:0] v, input logic [2:0] e);
    @(posedge i_clk) rx_valid <= 1'b1;
    rx_word <= {e, v};
    @(posedge i_clk) rx_valid <= 1'b0;
  endtask

  always @(posedge i_clk) begin
    cyc++;
    stall <= cyc[0] ^ cyc[2];
    if (cyc > 20000) begin
      err_total++;
      close_out;
    end
  end

  initial begin
    seed = 3;
    {err_total, check_count, cyc, n} = '0;
    {req, rx_valid, rx_word, modem_in, delta, stall, i_rst_n} = '0;
    repeat (3) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rdc(ADDR_LSR, 8'h60);
    rdc(ADDR_ISR, irq_status_reg(1'b0, ISR_NONE));
    rdc(ADDR_IER, IER_RST);
    rdc(ADDR_RSVD, 8'h00);
    // held character with a parity error, fifos off
    wr(ADDR_IER, 8'h05);
    d = 8'($random(seed));
    push(d, 3'b001);
    rdc(ADDR_LSR, 8'hE5);
    rdc(ADDR_ISR, irq_status_reg(1'b0, ISR_LS));
    check(irq, 8'h01);
    rdc(ADDR_HOLD, d);
    rdc(ADDR_LSR, 8'h60);
    rdc(ADDR_ISR, irq_status_reg(1'b0, ISR_NONE));
    // transmit ready: enable while empty, clear, refill
    wr(ADDR_IER, 8'h02);
    rdc(ADDR_ISR, irq_status_reg(1'b0, ISR_TX));
    rdc(ADDR_ISR, irq_status_reg(1'b0, ISR_NONE));
    d = 8'($random(seed));
    wr(ADDR_HOLD, d);
    #1;
    while (tx_valid !== 1'b0 && n < 40) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check(tx_valid, 8'h00);
    rdc(ADDR_LSR, 8'h20);
    check(last, d);
    rdc(ADDR_ISR, irq_status_reg(1'b0, ISR_TX));
    repeat (10) @(posedge i_clk);
    rdc(ADDR_LSR, 8'h60);
    // fifo mode, receive trigger of four
    wr(ADDR_IER, 8'h00);
    wr(ADDR_ISR, 8'h41);
    wr(ADDR_IER, 8'h01);
    for (int k = 0; k < 4; k++) begin
      q.push_back(8'($random(seed)));
      push(q[k], 3'b000);
      if (k == 2) rdc(ADDR_ISR, irq_status_reg(1'b1, ISR_NONE));
    end
    rdc(ADDR_ISR, irq_status_reg(1'b1, ISR_RX));
    rdc(ADDR_HOLD, q.pop_front());
    rdc(ADDR_ISR, irq_status_reg(1'b1, ISR_NONE));
    while (q.size() > 0) rdc(ADDR_HOLD, q.pop_front());
    rdc(ADDR_LSR, 8'h60);
    // polled fill to the brim, then one character too many
    wr(ADDR_IER, 8'h00);
    for (int k = 0; k < 16; k++) begin
      q.push_back(8'($random(seed)));
      push(q[k], 3'b000);
    end
    #1;
    check(rx_ready, 8'h00);
    check(irq, 8'h00);
    wr(ADDR_IER, 8'h04);
    push(8'($random(seed)), 3'b000);
    rdc(ADDR_ISR, irq_status_reg(1'b1, ISR_LS));
    rdc(ADDR_LSR, 8'h63);
    rdc(ADDR_ISR, irq_status_reg(1'b1, ISR_NONE));
    while (q.size() > 0) rdc(ADDR_HOLD, q.pop_front());
    // modem change
    wr(ADDR_IER, 8'h08);
    d = 8'({$random(seed)} % 15 + 1);
    @(posedge i_clk) delta <= d[3:0];
    modem_in <= 4'($random(seed));
    @(posedge i_clk) delta <= 4'h0;
    rdc(ADDR_ISR, irq_status_reg(1'b1, ISR_MS));
    rdc(ADDR_MSR, {modem_in, d[3:0]});
    rdc(ADDR_ISR, irq_status_reg(1'b1, ISR_NONE));
    // framing error held, then a soft reset through the gpio control slot
    push(8'($random(seed)), 3'b010);
    rdc(ADDR_LSR, 8'hE9);
    wr(4'hE, 8'h08);
    rdc(ADDR_LSR, 8'h60);
    // second reset in mid-run
    @(posedge i_clk) i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rdc(ADDR_IER, IER_RST);
    rdc(ADDR_ISR, irq_status_reg(1'b0, ISR_NONE));
    close_out;
  end
endmodule // uiel_line_status_tb

bind uiel_line_status uiel_line_status_chk #(.DEPTH(DEPTH)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_req(i_reg_req),
  .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
  .i_rx_valid(i_rx_valid), .i_rx_word(i_rx_word), .o_rx_ready(o_rx_ready),
  .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .i_tx_ready(i_tx_ready),
  .i_tsr_empty(i_tsr_empty), .i_modem_delta(i_modem_delta), .o_irq(o_irq));
